// ===== design/sensor_i2c_pkg.sv
// constants and types for the sensor two-wire slave port
`default_nettype none
package sensor_i2c_pkg;
  localparam int CLK_MHZ = 250;
  // spike suppression widths of the input filters
  localparam int FILT_NORM_NS = 50;
  localparam int FILT_HS_NS = 10;
  localparam int FILT_NORM_CYC = (FILT_NORM_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_HS_CYC = (FILT_HS_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMEOUT_MS = 30;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_MHZ * 1000;
  localparam logic [6:0] DEV_ADDR_BASE = 7'h48;
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [4:0] HS_CODE = 5'h01;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_LO = 2'h2;
  localparam logic [1:0] PTR_HI = 2'h3;
  localparam logic [4:0] OFS_TEMP = 5'h00;
  localparam logic [4:0] OFS_CFG = 5'h04;
  localparam logic [4:0] OFS_LO = 5'h08;
  localparam logic [4:0] OFS_HI = 5'h0c;
  localparam logic [4:0] OFS_STAT = 5'h10;
  localparam logic [15:0] TEMP_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] LO_RST = 16'h4b00;
  localparam logic [15:0] HI_RST = 16'h5000;
  localparam logic AC_RST = 1'h1;
  localparam int CFG_POL = 2;
  localparam int CFG_AC = 5;
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ACK, S_RX, S_TX, S_MACK, S_IGN
  } st_t;
endpackage
`default_nettype wire

// ===== design/sensor_i2c_slave_port.sv
// two-wire slave port of the temperature sensor with register bus
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`default_nettype none
module sensor_i2c_slave_port
  import sensor_i2c_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oen,
  input wire logic address_select_pin,
  output logic alert_condition_flag,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  // input synchronisers and glitch filters, one per bus line
  logic [1:0] lin;
  logic [1:0] lf;
  logic [3:0] flim;
  logic hs_q;
  assign lin = {sda_in, scl_in};
  assign flim = hs_q ? 4'(FILT_HS_CYC) : 4'(FILT_NORM_CYC);

  genvar g;
  for (g = 0; g < 2; g++) begin : g_line
    logic s1_q, s2_q, f_q, f_d;
    logic [3:0] fc_q, fc_d;
    always_comb begin
      fc_d = 4'h0;
      f_d = f_q;
      if (s2_q != f_q) begin
        if (fc_q >= flim - 4'h1) begin
          f_d = s2_q;
        end else begin
          fc_d = fc_q + 4'h1;
        end
      end
    end
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        s1_q <= 1'h1;
        s2_q <= 1'h1;
        f_q <= 1'h1;
        fc_q <= 4'h0;
      end else begin
        s1_q <= lin[g];
        s2_q <= s1_q;
        f_q <= f_d;
        fc_q <= fc_d;
      end
    end
    assign lf[g] = f_q;
  end

  logic scl_p_q, sda_p_q, as1_q, as2_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
      as1_q <= 1'h0;
      as2_q <= 1'h0;
    end else begin
      scl_p_q <= lf[0];
      sda_p_q <= lf[1];
      as1_q <= address_select_pin;
      as2_q <= as1_q;
    end
  end

  logic scl_f, sda_f, rise, fall, start, stop;
  logic [6:0] own;
  assign scl_f = lf[0];
  assign sda_f = lf[1];
  assign rise = scl_f && !scl_p_q;
  assign fall = !scl_f && scl_p_q;
  assign start = scl_f && scl_p_q && sda_p_q && !sda_f;
  assign stop = scl_f && scl_p_q && !sda_p_q && sda_f;
  assign own = DEV_ADDR_BASE | {6'h0, as2_q};

  // clock-low watchdog; saturates so it fires once per stall
  logic [TW-1:0] tc_q, tc_d;
  logic tmo;
  assign tmo = !scl_f && (tc_q == TW'(TIMEOUT_CYCLES - 1));
  always_comb begin
    tc_d = '0;
    if (!scl_f) begin
      tc_d = (tc_q == TW'(TIMEOUT_CYCLES)) ? tc_q : tc_q + TW'(1);
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tc_q <= '0;
    end else begin
      tc_q <= tc_d;
    end
  end

  // register file: temperature, configuration, lower and upper limit
  logic [15:0] temp_q, cfg_q, lo_q, hi_q;
  logic ac_q;

  function automatic logic [15:0] reg_word(input logic [1:0] p,
    input logic [15:0] t, input logic [15:0] c, input logic [15:0] l,
    input logic [15:0] h);
    logic [15:0] w;
    unique case (p)
      PTR_TEMP: w = t;
      PTR_CFG: w = c;
      PTR_LO: w = l;
      default: w = h;
    endcase
    return w;
  endfunction

  logic [15:0] cfg_rd;
  assign cfg_rd = cfg_q | (16'(ac_q) << CFG_AC);

  // serial state machine
  st_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, wb_q, wb_d, txb;
  logic [1:0] ptr_q, ptr_d, cnt_q, cnt_d;
  logic rw_q, rw_d, gc_q, gc_d, up_q, up_d, hs_d, oen_q, oen_d, we;
  logic [15:0] rword;
  assign rword = reg_word(ptr_q, temp_q, cfg_rd, lo_q, hi_q);
  assign txb = up_q ? rword[15:8] : rword[7:0];

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    wb_d = wb_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    rw_d = rw_q;
    gc_d = gc_q;
    up_d = up_q;
    hs_d = hs_q;
    oen_d = oen_q;
    we = 1'h0;
    if (tmo) begin
      st_d = S_IGN;
      oen_d = 1'h1;
    end else if (start) begin
      st_d = S_ADDR;
      bit_d = 4'h0;
      oen_d = 1'h1;
    end else if (stop) begin
      st_d = S_IDLE;
      oen_d = 1'h1;
      hs_d = 1'h0;
    end else if (rise) begin
      if (st_q == S_ADDR || st_q == S_RX) begin
        sh_d = {sh_q[6:0], sda_f};
        bit_d = bit_q + 4'h1;
      end else if (st_q == S_TX) begin
        bit_d = bit_q + 4'h1;
      end else if (st_q == S_MACK && sda_f) begin
        st_d = S_IGN;
      end
    end else if (fall) begin
      unique case (st_q)
        S_ADDR: begin
          if (bit_q == BIT_LAST) begin
            if (sh_q[7:3] == HS_CODE) begin
              hs_d = 1'h1;
              st_d = S_IGN;
            end else if (sh_q[7:1] == own || sh_q[7:1] == GC_ADDR) begin
              rw_d = sh_q[0];
              gc_d = (sh_q[7:1] == GC_ADDR);
              cnt_d = 2'h0;
              up_d = 1'h1;
              oen_d = 1'h0;
              st_d = S_ACK;
            end else begin
              st_d = S_IGN;
            end
          end
        end
        S_RX: begin
          if (bit_q == BIT_LAST) begin
            if (gc_q && cnt_q != 2'h0) begin
              st_d = S_IGN;
            end else begin
              oen_d = 1'h0;
              st_d = S_ACK;
              cnt_d = (cnt_q == 2'h2) ? 2'h1 : cnt_q + 2'h1;
              if (!gc_q) begin
                unique case (cnt_q)
                  2'h0: ptr_d = sh_q[1:0];
                  2'h1: wb_d = sh_q;
                  default: we = 1'h1;
                endcase
              end
            end
          end
        end
        S_ACK, S_MACK: begin
          bit_d = 4'h0;
          if (st_q == S_ACK && !rw_q) begin
            oen_d = 1'h1;
            st_d = S_RX;
          end else begin
            sh_d = txb;
            oen_d = txb[7];
            st_d = S_TX;
          end
        end
        S_TX: begin
          if (bit_q == BIT_LAST) begin
            oen_d = 1'h1;
            st_d = S_MACK;
            up_d = !up_q;
          end else begin
            sh_d = {sh_q[6:0], 1'h0};
            oen_d = sh_q[6];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      wb_q <= 8'h00;
      ptr_q <= PTR_TEMP;
      cnt_q <= 2'h0;
      rw_q <= 1'h0;
      gc_q <= 1'h0;
      up_q <= 1'h1;
      hs_q <= 1'h0;
      oen_q <= 1'h1;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      wb_q <= wb_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      rw_q <= rw_d;
      gc_q <= gc_d;
      up_q <= up_d;
      hs_q <= hs_d;
      oen_q <= oen_d;
    end
  end

  // open drain: only ever pull low, clock pin has no driver at all
  assign sda_out = 1'h0;
  assign sda_oen = oen_q;

  // bus slave: one wait cycle, then the access completes
  logic wait_q, wait_d, ac_d, commit;
  logic [31:0] rd_q, rd_d;
  logic [15:0] temp_d, cfg_d, lo_d, hi_d, wd16;
  assign commit = (read || write) && !wait_q;

  function automatic logic [15:0] merge(input logic [15:0] o,
    input logic [31:0] d, input logic [3:0] be);
    logic [15:0] m;
    m = o;
    if (be[0]) begin
      m[7:0] = d[7:0];
    end
    if (be[1]) begin
      m[15:8] = d[15:8];
    end
    return m;
  endfunction

  always_comb begin
    wait_d = 1'h1;
    rd_d = rd_q;
    temp_d = temp_q;
    cfg_d = cfg_q;
    lo_d = lo_q;
    hi_d = hi_q;
    wd16 = {wb_q, sh_q};
    if ((read || write) && wait_q) begin
      wait_d = 1'h0;
      unique case (address)
        OFS_TEMP: rd_d = {16'h0, temp_q};
        OFS_CFG: rd_d = {16'h0, cfg_rd};
        OFS_LO: rd_d = {16'h0, lo_q};
        OFS_HI: rd_d = {16'h0, hi_q};
        OFS_STAT: rd_d = {28'h0, hs_q, st_q != S_IDLE, ptr_q};
        default: rd_d = 32'h0;
      endcase
    end
    if (commit && write) begin
      unique case (address)
        OFS_TEMP: temp_d = merge(temp_q, writedata, byteenable);
        OFS_CFG: cfg_d = merge(cfg_q, writedata, byteenable);
        OFS_LO: lo_d = merge(lo_q, writedata, byteenable);
        OFS_HI: hi_d = merge(hi_q, writedata, byteenable);
        default: ;
      endcase
    end
    // serial write lands after the bus write, so it wins a tie
    if (we) begin
      unique case (ptr_q)
        PTR_CFG: cfg_d = wd16;
        PTR_LO: lo_d = wd16;
        PTR_HI: hi_d = wd16;
        default: ;
      endcase
    end
    cfg_d[CFG_AC] = 1'h0;
    ac_d = ac_q;
    if ($signed(temp_q[15:4]) >= $signed(hi_q[15:4])) begin
      ac_d = cfg_q[CFG_POL];
    end else if ($signed(temp_q[15:4]) <= $signed(lo_q[15:4])) begin
      ac_d = !cfg_q[CFG_POL];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 1'h1;
      rd_q <= 32'h0;
      temp_q <= TEMP_RST;
      cfg_q <= CFG_RST;
      lo_q <= LO_RST;
      hi_q <= HI_RST;
      ac_q <= AC_RST;
    end else begin
      wait_q <= wait_d;
      rd_q <= rd_d;
      temp_q <= temp_d;
      cfg_q <= cfg_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      ac_q <= ac_d;
    end
  end

  assign waitrequest = wait_q;
  assign readdata = rd_q;
  assign alert_condition_flag = ac_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_addr_ack;
    fall && st_q == S_ADDR && bit_q == BIT_LAST && sh_q[7:1] == own
      |=> !sda_oen && st_q == S_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");

  property p_hs_nack;
    fall && st_q == S_ADDR && bit_q == BIT_LAST && sh_q[7:3] == HS_CODE
      |=> sda_oen && hs_q && flim == 4'(FILT_HS_CYC);
  endproperty
  a_hs_nack: assert property (p_hs_nack)
    else $error("high-speed code acked or filters not switched");

  property p_stop_hs;
    stop && !tmo |=> !hs_q && sda_oen && st_q == S_IDLE;
  endproperty
  a_stop_hs: assert property (p_stop_hs)
    else $error("stop did not leave high-speed mode");

  property p_ptr_hold;
    !(fall && st_q == S_RX && cnt_q == 2'h0) |=> $stable(ptr_q);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("pointer changed outside pointer byte");

  property p_tx_first;
    fall && st_q == S_ACK && rw_q && !start && !stop && !tmo
      |=> st_q == S_TX && sh_q == rword[15:8] && sda_oen == sh_q[7];
  endproperty
  a_tx_first: assert property (p_tx_first)
    else $error("read did not start with upper byte");

  property p_gc_third;
    fall && st_q == S_RX && gc_q && cnt_q != 2'h0 && bit_q == BIT_LAST
      && !start && !stop && !tmo |=> sda_oen [*3];
  endproperty
  a_gc_third: assert property (p_gc_third)
    else $error("general call byte after second was acked");

  property p_timeout;
    tmo |=> sda_oen && st_q == S_IGN;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not free the data line");

  property p_ignore;
    (st_q == S_IGN || st_q == S_IDLE) && !start
      |=> (st_q == S_IGN || st_q == S_IDLE) && sda_oen;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("bus activity answered before start");

  property p_nomatch;
    fall && st_q == S_ADDR && bit_q == BIT_LAST && sh_q[7:1] != own
      && sh_q[7:1] != GC_ADDR && !start && !stop && !tmo
      |=> st_q == S_IGN && sda_oen;
  endproperty
  a_nomatch: assert property (p_nomatch)
    else $error("foreign address not ignored");

  property p_nack_release;
    rise && st_q == S_MACK && sda_f && !tmo && !start && !stop
      |=> st_q == S_IGN ##0 sda_oen [*4];
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("data not released after master nack");

  property p_ac_map;
    $signed(temp_q[15:4]) >= $signed(hi_q[15:4])
      |=> alert_condition_flag == $past(cfg_q[CFG_POL]);
  endproperty
  a_ac_map: assert property (p_ac_map)
    else $error("alert flag wrong above upper limit");

  property p_bus_wait;
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait)
    else $error("bus access did not complete in two cycles");
endmodule
`default_nettype wire

// ===== verif/two_wire_master.sv
// behavioural two-wire bus master facing the sensor port
`default_nettype none
module two_wire_master #(
  parameter int T = 64
) (
  output logic scl,
  output logic sda_m,
  input wire logic sda,
  output logic res_v,
  output logic [31:0] res
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    res_v = 1'b0;
    res = '0;
  end
  // hands one observed value to the bench
  task automatic put(input logic [31:0] v);
    res = v;
    res_v = 1'b1;
    #1 res_v = 1'b0;
  endtask
  // also a repeated start; scl stands high between frames
  task automatic start();
    #T sda_m = 1'b1;
    #T scl = 1'b1;
    #T sda_m = 1'b0;
    #T scl = 1'b0;
  endtask
  task automatic stop();
    #T sda_m = 1'b0;
    #T scl = 1'b1;
    #T sda_m = 1'b1;
    #T;
  endtask
  // sample mid high phase, well after the slave's output delay
  task automatic clk_bit(input logic b, output logic s);
    #T sda_m = b;
    #T scl = 1'b1;
    #T s = sda;
    #T scl = 1'b0;
  endtask
  task automatic send8(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    sda_m = 1'b1;
  endtask
  // reports 1 when the slave pulled data low in the ack slot
  task automatic wr_byte(input logic [7:0] d);
    logic s;
    send8(d);
    clk_bit(1'b1, s);
    put({31'h0, !s});
  endtask
  // acks the byte when ack is set, nacks it otherwise
  task automatic rd_byte(input logic ack);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(!ack, s);
    put({24'h0, d});
  endtask
endmodule
`default_nettype wire

// ===== verif/sensor_i2c_slave_port_tb_top.sv
// self-checking bench for the sensor two-wire slave port
`default_nettype none
module sensor_i2c_slave_port_tb_top import sensor_i2c_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TO = 2000;
  `define CMP(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch at %0t: got %h want %h", $time, g, e); end end
  logic mclk;
  logic rstn;
  logic asp;
  logic [4:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  wire [31:0] readdata;
  wire waitrequest;
  wire sda_out;
  wire sda_oen;
  wire flag;
  wire scl;
  wire sda_m;
  wire res_v;
  wire [31:0] res;
  // open drain wire with pull-up
  wire sda = sda_m & (sda_oen | sda_out);
  int seed = 96;
  int mismatches = 0;
  int tests_run = 0;
  logic [63:0] exp_q[$];
  logic [15:0] v;
  // cfg written, temperature written, expected flag
  logic [32:0] al [4] = '{{16'h0, HI_RST, 1'b0}, {16'h0, LO_RST, 1'b1},
    {16'h4, LO_RST, 1'b0}, {16'h4, HI_RST, 1'b1}};
  always #2 mclk = ~mclk;
  sensor_i2c_slave_port #(.TIMEOUT_CYCLES(TO)) uut (
    .mclk(mclk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oen(sda_oen), .address_select_pin(asp),
    .alert_condition_flag(flag), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest));
  two_wire_master #(.T(64)) m (
    .scl(scl), .sda_m(sda_m), .sda(sda), .res_v(res_v), .res(res));
  task automatic note(input logic [31:0] e, input logic [31:0] mk = '1);
    exp_q.push_back({mk, e});
  endtask
  task automatic check(input logic [31:0] g);
    logic [63:0] n;
    if (exp_q.size() == 0) begin
      mismatches++;
      $display("mismatch at %0t: result without a note", $time);
    end else begin
      n = exp_q.pop_front();
      `CMP(g & n[63:32], n[31:0])
    end
  endtask
  always @(posedge mclk) if (read && waitrequest === 1'b0) check(readdata);
  always @(posedge res_v) check(res);
  // holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    // upper enables are ignored by the port, so let them wander
    byteenable <= {2'($random(seed)), 2'h3};
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("mismatch at %0t: bus hang", $time);
    end
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [31:0] mk = '1);
    note(e, mk);
    bus(1'b0, a, '0);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic complete_run();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    complete_run();
  end
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    asp = 1'b0;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = '0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (30) @(posedge mclk);
    rd(5'h00, 32'h0);
    rd(5'h04, 32'h20);
    rd(5'h08, {16'h0, LO_RST});
    rd(5'h0c, {16'h0, HI_RST});
    rd(5'h10, 32'h0);
    bus(1'b1, 5'h14, 32'hffff);
    rd(5'h14, 32'h0);
    done("reset");
    v = 16'($random(seed));
    bus(1'b1, 5'h00, {16'h0, v});
    m.start();
    note(32'h1); m.wr_byte(8'h91);
    note({24'h0, v[15:8]}); m.rd_byte(1'b1);
    note({24'h0, v[7:0]}); m.rd_byte(1'b0);
    m.stop();
    done("reset pointer read");
    for (int p = 0; p < 2; p++) begin
      asp <= p[0];
      v = 16'($random(seed));
      m.start();
      note(32'h0); m.wr_byte({DEV_ADDR_BASE | {6'h0, !p[0]}, 1'b0});
      note(32'h0); m.wr_byte(8'h00);
      m.stop();
      m.start();
      note(32'h1); m.wr_byte({DEV_ADDR_BASE | {6'h0, p[0]}, 1'b0});
      note(32'h1); m.wr_byte(8'h03);
      note(32'h1); m.wr_byte(v[15:8]);
      note(32'h1); m.wr_byte(v[7:0]);
      m.stop();
      rd(5'h0c, {16'h0, v});
      rd(5'h10, 32'h3);
    end
    done("address and write");
    // nack ends each read so the repeated start finds data released
    for (int k = 0; k < 3; k++) begin
      m.start();
      note(32'h1); m.wr_byte(k == 2 ? 8'h01 : 8'h93);
      note({24'h0, v[15:8]}); m.rd_byte(1'b0);
    end
    m.stop();
    done("repeated reads");
    m.start();
    note(32'h1); m.wr_byte(8'h00);
    note(32'h1); m.wr_byte(8'($random(seed)));
    note(32'h0); m.wr_byte(8'h02);
    m.stop();
    rd(5'h10, 32'h3);
    rd(5'h0c, {16'h0, v});
    done("general call");
    m.start();
    note(32'h0); m.wr_byte({5'h01, 3'($random(seed))});
    rd(5'h10, 32'hb, 32'hb);
    m.start();
    note(32'h1); m.wr_byte(8'h93);
    note({24'h0, v[15:8]}); m.rd_byte(1'b0);
    rd(5'h10, 32'hb, 32'hb);
    m.stop();
    repeat (20) @(posedge mclk);
    rd(5'h10, 32'h3);
    done("high speed");
    bus(1'b1, 5'h08, {16'h0, LO_RST});
    bus(1'b1, 5'h0c, {16'h0, HI_RST});
    foreach (al[i]) begin
      bus(1'b1, 5'h04, {16'h0, al[i][32:17]});
      bus(1'b1, 5'h00, {16'h0, al[i][16:1]});
      repeat (4) @(posedge mclk);
      rd(5'h04, {16'h0, al[i][32:17]} | {26'h0, al[i][0], 5'h0});
      note({31'h0, al[i][0]}); m.put({31'h0, flag});
    end
    done("alert polarity");
    // scl parked low in the ack slot while the slave holds data
    m.start();
    m.send8(8'h92);
    #128;
    note(32'h0); m.put({31'h0, sda});
    #(TO * 4 + 400);
    note(32'h1); m.put({31'h0, sda});
    note(32'h0); m.wr_byte(8'h92);
    m.stop();
    m.start();
    note(32'h1); m.wr_byte(8'h92);
    m.stop();
    done("timeout");
    repeat (20) @(posedge mclk);
    if (exp_q.size() != 0) begin
      mismatches++;
      $display("mismatch at %0t: notes left over", $time);
    end
    complete_run();
  end
endmodule
`default_nettype wire
